// ---- logic/cbsc_pkg.sv ----
package cbsc_pkg;
   localparam logic [7:0] SYS_CTRL_OFF = 8'h80;
   localparam logic [31:0] SYS_CTRL_RST = 32'h0844_9060;
   localparam int DOWN_BURST_BIT = 15;
   localparam int UP_BURST_BIT = 14;
   localparam int ACTIVITY_BIT = 13;
   localparam int RSVD_ONE_BIT = 12;
   localparam int STREAM_BIT = 11;
   localparam int UP_DELAY_BIT = 10;
   localparam int DOWN_DELAY_BIT = 9;
   localparam int INTERROG_BIT = 8;
   localparam int AUTO_GATE_BIT = 7;
   localparam int SAVING_BIT = 6;
   localparam int LOCK_BIT = 5;
   localparam int PARITY_BIT = 4;
   localparam int VOLT_BIT = 2;
   localparam int HOLD_BIT = 1;
   localparam int MUX_BIT = 0;
   // Host-writable bits of the low half; status bits 13..8 are excluded
   localparam logic [15:0] LOW_WR_MASK = 16'hC0FF;
   localparam int CLK_PERIOD_NS = 4;
   localparam int PWR_UP_DELAY_NS = 2000;
   localparam int PWR_DOWN_DELAY_NS = 1000;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] PWR_UP_CYCLES =
      CNT_W'((PWR_UP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] PWR_DOWN_CYCLES =
      CNT_W'((PWR_DOWN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   typedef enum logic [1:0] {
      CBSC_IDLE = 2'b00,
      CBSC_STREAM = 2'b01,
      CBSC_DELAY = 2'b10
   } cbsc_pwr_state_t;
endpackage

// ---- logic/cbsc_sys_ctrl.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Downstream memory-read bursting is allowed only while bit 15 is set, and it resets set.
// - Upstream memory-read bursting is allowed only while bit 14 is set, and it resets clear.
// - Bit 13 is set by any card access and cleared by a read of it, resetting clear.
// - Reserved bit 12 always reads as one.
// - Bit 11 is high from a power change request until the stream is sent and its delay has expired.
// - Bit 10 sets when a power-up stream is sent and clears only when the power-up delay expires.
// - Bit 9 sets when a power-down stream is sent and clears only when the power-down delay expires.
// - Bit 8 follows the card interrogation in progress and resets clear.
// - The legacy automatic power-switch bit only works while bit 7 is set, which resets clear.
// - With bit 6 set, an idle inserted card with stopped clock has its state machine clock gated off.
// - Identity registers are writable while bit 5 is clear and read-only while set, its reset value.
// - Card data parity errors reach the system error signal only while bit 4 is set.
// - With bit 1 set neither the card clock nor the host clock may be stopped by the clock-run protocols.
// - With bit 0 clear ring-indicate and PME share the terminal with ring-indicate first; set, only PME drives it.
// - The register is one doubleword at configuration offset 80h resetting to 0844 9060h.
module cbsc_sys_ctrl (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic card_access_i,
   input wire logic pwr_change_req_i,
   input wire logic pwr_dir_up_i,
   input wire logic pwr_stream_sent_i,
   input wire logic interrog_active_i,
   input wire logic legacy_auto_switch_i,
   input wire logic card_inserted_i,
   input wire logic card_idle_i,
   input wire logic card_clk_stopped_i,
   input wire logic card_parity_err_i,
   input wire logic card_clk_stop_req_i,
   input wire logic host_clk_stop_req_i,
   input wire logic ring_indicate_en_i,
   input wire logic ring_indicate_i,
   input wire logic pme_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   output logic down_read_burst_en_o,
   output logic up_read_burst_en_o,
   output logic auto_switch_en_o,
   output logic card_sm_clk_en_o,
   output logic identity_wr_en_o,
   output logic serr_o,
   output logic card_clk_stop_ok_o,
   output logic host_clk_stop_ok_o,
   output logic legacy_voltage_select_o,
   output logic ring_indicate_out_o
);
   logic [31:0] ctrl_r, ctrl_nxt;
   logic activity_r, activity_nxt;
   logic interrog_r, interrog_nxt;
   cbsc_pkg::cbsc_pwr_state_t pwr_state_r, pwr_state_nxt;
   logic up_delay_r, up_delay_nxt;
   logic down_delay_r, down_delay_nxt;
   logic [cbsc_pkg::CNT_W-1:0] delay_cnt_r, delay_cnt_nxt;
   logic [31:0] rdata_nxt;
   logic rvalid_nxt;
   logic hit_wr, hit_rd, stream_busy;

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   assign hit_wr = cfg_wr_i && (cfg_addr_i == cbsc_pkg::SYS_CTRL_OFF);
   assign hit_rd = cfg_rd_i && (cfg_addr_i == cbsc_pkg::SYS_CTRL_OFF);
   assign stream_busy = (pwr_state_r != cbsc_pkg::CBSC_IDLE);

   function automatic logic [31:0] view(input logic [31:0] c, input logic act, input logic busy,
                                        input logic up, input logic dn, input logic intr);
      logic [31:0] v;
      v = c;
      v[cbsc_pkg::ACTIVITY_BIT] = act;
      v[cbsc_pkg::RSVD_ONE_BIT] = 1'b1;
      v[cbsc_pkg::STREAM_BIT] = busy;
      v[cbsc_pkg::UP_DELAY_BIT] = up;
      v[cbsc_pkg::DOWN_DELAY_BIT] = dn;
      v[cbsc_pkg::INTERROG_BIT] = intr;
      view = v;
   endfunction

   // Control bits and read port
   always_comb begin
      logic [31:0] wmask;
      wmask = be_mask(cfg_be_i) & {16'hFFFF, cbsc_pkg::LOW_WR_MASK};
      ctrl_nxt = ctrl_r;
      if (hit_wr) begin
         ctrl_nxt = (ctrl_r & ~wmask) | (cfg_wdata_i & wmask);
      end
      rvalid_nxt = cfg_rd_i;
      rdata_nxt = 32'h0000_0000;
      if (hit_rd) begin
         rdata_nxt = view(ctrl_r, activity_r, stream_busy, up_delay_r, down_delay_r, interrog_r);
      end
      // Set beats the read clear so an access in the read cycle is kept
      activity_nxt = activity_r;
      if (hit_rd && cfg_be_i[1]) begin
         activity_nxt = 1'b0;
      end
      if (card_access_i) begin
         activity_nxt = 1'b1;
      end
      interrog_nxt = interrog_active_i;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= cbsc_pkg::SYS_CTRL_RST;
         activity_r <= 1'b0;
         interrog_r <= 1'b0;
         cfg_rdata_o <= 32'h0000_0000;
         cfg_rvalid_o <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         activity_r <= activity_nxt;
         interrog_r <= interrog_nxt;
         cfg_rdata_o <= rdata_nxt;
         cfg_rvalid_o <= rvalid_nxt;
      end
   end

   // Power-switch stream tracking; a request while busy is absorbed
   always_comb begin
      pwr_state_nxt = pwr_state_r;
      up_delay_nxt = up_delay_r;
      down_delay_nxt = down_delay_r;
      delay_cnt_nxt = delay_cnt_r;
      case (pwr_state_r)
         cbsc_pkg::CBSC_IDLE: begin
            if (pwr_change_req_i) begin
               pwr_state_nxt = cbsc_pkg::CBSC_STREAM;
            end
         end
         cbsc_pkg::CBSC_STREAM: begin
            if (pwr_stream_sent_i) begin
               pwr_state_nxt = cbsc_pkg::CBSC_DELAY;
               up_delay_nxt = pwr_dir_up_i;
               down_delay_nxt = !pwr_dir_up_i;
               delay_cnt_nxt = pwr_dir_up_i ? cbsc_pkg::PWR_UP_CYCLES : cbsc_pkg::PWR_DOWN_CYCLES;
            end
         end
         cbsc_pkg::CBSC_DELAY: begin
            if (delay_cnt_r == 1) begin
               pwr_state_nxt = cbsc_pkg::CBSC_IDLE;
               up_delay_nxt = 1'b0;
               down_delay_nxt = 1'b0;
               delay_cnt_nxt = '0;
            end else begin
               delay_cnt_nxt = delay_cnt_r - 1'b1;
            end
         end
         default: begin
            pwr_state_nxt = cbsc_pkg::CBSC_IDLE;
            up_delay_nxt = 1'b0;
            down_delay_nxt = 1'b0;
            delay_cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_state_r <= cbsc_pkg::CBSC_IDLE;
         up_delay_r <= 1'b0;
         down_delay_r <= 1'b0;
         delay_cnt_r <= '0;
      end else begin
         pwr_state_r <= pwr_state_nxt;
         up_delay_r <= up_delay_nxt;
         down_delay_r <= down_delay_nxt;
         delay_cnt_r <= delay_cnt_nxt;
      end
   end

   // Control outputs, registered so every port comes from a flip-flop
   logic dn_burst_nxt, up_burst_nxt, auto_nxt, sm_clk_nxt, id_wr_nxt, serr_nxt;
   logic card_stop_nxt, host_stop_nxt, volt_nxt, ring_nxt;
   always_comb begin
      dn_burst_nxt = ctrl_r[cbsc_pkg::DOWN_BURST_BIT];
      up_burst_nxt = ctrl_r[cbsc_pkg::UP_BURST_BIT];
      auto_nxt = legacy_auto_switch_i && ctrl_r[cbsc_pkg::AUTO_GATE_BIT];
      sm_clk_nxt = !(ctrl_r[cbsc_pkg::SAVING_BIT] && card_inserted_i && card_idle_i
                     && card_clk_stopped_i);
      id_wr_nxt = !ctrl_r[cbsc_pkg::LOCK_BIT];
      serr_nxt = card_parity_err_i && ctrl_r[cbsc_pkg::PARITY_BIT];
      card_stop_nxt = card_clk_stop_req_i && !ctrl_r[cbsc_pkg::HOLD_BIT];
      host_stop_nxt = host_clk_stop_req_i && !ctrl_r[cbsc_pkg::HOLD_BIT];
      volt_nxt = ctrl_r[cbsc_pkg::VOLT_BIT];
      // With bit 0 clear, ring-indicate masks PME while enabled; with bit 0 set, PME alone drives the pin
      if (ctrl_r[cbsc_pkg::MUX_BIT]) begin
         ring_nxt = pme_i;
      end else if (ring_indicate_en_i) begin
         ring_nxt = ring_indicate_i;
      end else begin
         ring_nxt = pme_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         down_read_burst_en_o <= 1'b1;
         up_read_burst_en_o <= 1'b0;
         auto_switch_en_o <= 1'b0;
         card_sm_clk_en_o <= 1'b1;
         identity_wr_en_o <= 1'b0;
         serr_o <= 1'b0;
         card_clk_stop_ok_o <= 1'b0;
         host_clk_stop_ok_o <= 1'b0;
         legacy_voltage_select_o <= 1'b0;
         ring_indicate_out_o <= 1'b0;
      end else begin
         down_read_burst_en_o <= dn_burst_nxt;
         up_read_burst_en_o <= up_burst_nxt;
         auto_switch_en_o <= auto_nxt;
         card_sm_clk_en_o <= sm_clk_nxt;
         identity_wr_en_o <= id_wr_nxt;
         serr_o <= serr_nxt;
         card_clk_stop_ok_o <= card_stop_nxt;
         host_clk_stop_ok_o <= host_stop_nxt;
         legacy_voltage_select_o <= volt_nxt;
         ring_indicate_out_o <= ring_nxt;
      end
   end

   burst_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hit_wr && cfg_be_i[1] |=> ##1 down_read_burst_en_o == $past(cfg_wdata_i[15], 2))
      else $error("downstream burst enable not following write");
   up_burst_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hit_wr && cfg_be_i[1] |=> ##1 up_read_burst_en_o == $past(cfg_wdata_i[14], 2))
      else $error("upstream burst enable not following write");
   activity_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      card_access_i |=> activity_r)
      else $error("socket activity lost");
   activity_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hit_rd && cfg_be_i[1] && !card_access_i |=> !activity_r)
      else $error("socket activity not cleared by read");
   rsvd_one_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hit_rd |=> cfg_rvalid_o && cfg_rdata_o[12])
      else $error("reserved bit 12 not one");
   stream_busy_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      pwr_state_r == cbsc_pkg::CBSC_IDLE && pwr_change_req_i |=> stream_busy)
      else $error("power stream flag not raised");
   up_delay_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      pwr_state_r == cbsc_pkg::CBSC_STREAM && pwr_stream_sent_i && pwr_dir_up_i |=> up_delay_r[*8])
      else $error("power-up delay flag ended early");
   down_delay_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      pwr_state_r == cbsc_pkg::CBSC_STREAM && pwr_stream_sent_i && !pwr_dir_up_i
      |=> down_delay_r ##[1:300] !down_delay_r)
      else $error("power-down delay flag wrong");
   auto_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ctrl_r[cbsc_pkg::AUTO_GATE_BIT] |=> !auto_switch_en_o)
      else $error("auto switch active while gated");
   serr_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !ctrl_r[cbsc_pkg::PARITY_BIT] |=> !serr_o)
      else $error("parity error reported while disabled");
   clk_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ctrl_r[cbsc_pkg::HOLD_BIT] |=> !card_clk_stop_ok_o && !host_clk_stop_ok_o)
      else $error("clock stop allowed during hold");
   pme_only_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ctrl_r[cbsc_pkg::MUX_BIT] |=> ring_indicate_out_o == $past(pme_i))
      else $error("shared terminal not PME only");
   status_ro_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      hit_wr |=> ctrl_r[13:8] == $past(ctrl_r[13:8]))
      else $error("status bits written by host");
   read_clear_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      activity_r ##1 hit_rd ##1 !activity_r);
   power_up_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      up_delay_r ##1 !up_delay_r);
   power_down_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      down_delay_r ##1 !down_delay_r);
   clk_gate_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) !card_sm_clk_en_o);
endmodule

// ---- verification/cbsc_host_model.sv ----
`timescale 1ns/1ps
module cbsc_host_model (
   input wire logic sys_clk_i,
   input wire logic [31:0] cfg_rdata_i,
   input wire logic cfg_rvalid_i,
   output logic cfg_wr_o,
   output logic cfg_rd_o,
   output logic [7:0] cfg_addr_o,
   output logic [3:0] cfg_be_o,
   output logic [31:0] cfg_wdata_o
);
   initial begin
      cfg_wr_o = 1'b0;
      cfg_rd_o = 1'b0;
      cfg_addr_o = 8'h00;
      cfg_be_o = 4'h0;
      cfg_wdata_o = 32'h0000_0000;
   end
   task automatic cfg_write(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
      @(negedge sys_clk_i);
      cfg_addr_o = addr;
      cfg_be_o = be;
      cfg_wdata_o = data;
      cfg_wdata_o[3] = cbsc_pkg::SYS_CTRL_RST[3];
      cfg_wr_o = 1'b1;
      @(negedge sys_clk_i);
      cfg_wr_o = 1'b0;
      // Released data lines must not keep showing the last value
      cfg_wdata_o = ~cfg_wdata_o;
   endtask
   task automatic cfg_read(input logic [7:0] addr, output logic [31:0] data);
      @(negedge sys_clk_i);
      cfg_addr_o = addr;
      cfg_be_o = 4'hF;
      cfg_rd_o = 1'b1;
      @(negedge sys_clk_i);
      cfg_rd_o = 1'b0;
      data = (cfg_rvalid_i === 1'b1) ? cfg_rdata_i : 32'hXXXX_XXXX;
   endtask
endmodule

// ---- verification/test_card_bridge_system_control_low.sv ----
`timescale 1ns/1ps
module test_card_bridge_system_control_low;
   logic sys_clk_i;
   logic rst_n_i;
   logic cfg_wr;
   logic cfg_rd;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata;
   logic [31:0] rdata;
   logic [31:0] rd_val;
   logic rvalid;
   // {legacy_auto, inserted, idle, clk_stopped, parity, cstop, hstop, ri_en, ri, pme}
   logic [9:0] ctl;
   // {card_access, interrog, pwr_req, pwr_dir_up, pwr_sent}
   logic [4:0] stim;
   wire [9:0] outs;
   int mismatches;
   int tests_run;

   cbsc_sys_ctrl u_cbsc_sys_ctrl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr),
      .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
      .card_access_i(stim[4]), .pwr_change_req_i(stim[2]), .pwr_dir_up_i(stim[1]),
      .pwr_stream_sent_i(stim[0]), .interrog_active_i(stim[3]), .legacy_auto_switch_i(ctl[9]),
      .card_inserted_i(ctl[8]), .card_idle_i(ctl[7]), .card_clk_stopped_i(ctl[6]),
      .card_parity_err_i(ctl[5]), .card_clk_stop_req_i(ctl[4]), .host_clk_stop_req_i(ctl[3]),
      .ring_indicate_en_i(ctl[2]), .ring_indicate_i(ctl[1]), .pme_i(ctl[0]),
      .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .down_read_burst_en_o(outs[9]),
      .up_read_burst_en_o(outs[8]), .auto_switch_en_o(outs[7]), .card_sm_clk_en_o(outs[6]),
      .identity_wr_en_o(outs[5]), .serr_o(outs[4]), .card_clk_stop_ok_o(outs[3]),
      .host_clk_stop_ok_o(outs[2]), .legacy_voltage_select_o(outs[1]), .ring_indicate_out_o(outs[0]));

   cbsc_host_model u_cbsc_host_model (.sys_clk_i(sys_clk_i), .cfg_rdata_i(rdata), .cfg_rvalid_i(rvalid),
      .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_addr_o(cfg_addr), .cfg_be_o(cfg_be), .cfg_wdata_o(cfg_wdata));

   task automatic report_and_stop();
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
      u_cbsc_host_model.cfg_read(addr, rd_val);
      tests_run++;
      if ((rd_val & mask) !== exp) begin
         mismatches++;
         $display("unexpected at %0t: read %h got %h want %h", $time, addr, rd_val & mask, exp);
      end
   endtask
   task automatic chk_outs(input logic [9:0] exp);
      tests_run++;
      if (outs !== exp) begin
         mismatches++;
         $display("unexpected at %0t: outputs %b want %b", $time, outs, exp);
      end
   endtask
   task automatic wr_settle(input logic [15:0] low);
      u_cbsc_host_model.cfg_write(8'h80, 4'h3, {16'hFFFF, low});
      repeat (3) @(negedge sys_clk_i);
   endtask

   task automatic test_reset_map();
      chk_outs(10'h240);
      rd_chk(8'h80, 32'hFFFF_FFFF, cbsc_pkg::SYS_CTRL_RST);
      rd_chk(8'h84, 32'hFFFF_FFFF, 32'h0000_0000);
      u_cbsc_host_model.cfg_write(8'h84, 4'hF, 32'h0000_0000);
      rd_chk(8'h80, 32'hFFFF_FFFF, cbsc_pkg::SYS_CTRL_RST);
   endtask
   task automatic test_controls();
      @(negedge sys_clk_i);
      ctl = 10'h3FD;
      // Status bits 13 and 11..8 written as ones must stay clear; reserved bit 12 stays one
      wr_settle(16'h7FF7);
      chk_outs(10'h193);
      rd_chk(8'h80, 32'hFFFF_FFFF, 32'h0844_50F7);
      wr_settle(16'h0000);
      chk_outs(10'h06C);
      rd_chk(8'h80, 32'hFFFF_FFFF, 32'h0844_1000);
      wr_settle(16'h9060);
      chk_outs(10'h20C);
      // Shared terminal falls back to PME with ring-indicate off, and follows ring-indicate when on
      @(negedge sys_clk_i);
      ctl = 10'h001;
      repeat (2) @(negedge sys_clk_i);
      chk_outs(10'h241);
      ctl = 10'h006;
      repeat (2) @(negedge sys_clk_i);
      chk_outs(10'h241);
      @(negedge sys_clk_i);
      ctl = 10'h000;
   endtask
   task automatic test_status();
      @(negedge sys_clk_i);
      stim = 5'h18;
      @(negedge sys_clk_i);
      stim = 5'h08;
      rd_chk(8'h80, 32'h0000_2100, 32'h0000_2100);
      @(negedge sys_clk_i);
      stim = 5'h00;
      @(negedge sys_clk_i);
      rd_chk(8'h80, 32'h0000_2100, 32'h0000_0000);
   endtask
   task automatic test_power(input logic dir_up, input int n, input logic [31:0] flag);
      @(negedge sys_clk_i);
      stim = 5'h04;
      @(negedge sys_clk_i);
      stim = 5'h00;
      rd_chk(8'h80, 32'h0000_0E00, 32'h0000_0800);
      @(negedge sys_clk_i);
      stim = {3'b000, dir_up, 1'b1};
      @(negedge sys_clk_i);
      stim = 5'h00;
      rd_chk(8'h80, 32'h0000_0E00, 32'h0000_0800 | flag);
      // Sample the last cycle of the delay, then the second cycle after it ends
      repeat (n - 4) @(negedge sys_clk_i);
      rd_chk(8'h80, 32'h0000_0E00, 32'h0000_0800 | flag);
      rd_chk(8'h80, 32'h0000_0E00, 32'h0000_0000);
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   // Whole run is about 1000 cycles; give it twenty times that
   initial begin
      #80000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      rst_n_i = 1'b0;
      ctl = 10'h000;
      stim = 5'h00;
      mismatches = 0;
      tests_run = 0;
      repeat (12) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      @(negedge sys_clk_i);
      test_reset_map();
      test_controls();
      test_status();
      test_power(1'b1, cbsc_pkg::PWR_UP_CYCLES, 32'h0000_0400);
      test_power(1'b0, cbsc_pkg::PWR_DOWN_CYCLES, 32'h0000_0200);
      report_and_stop();
   end
endmodule
